// [ritm_pkg.sv]
package ritm_pkg;
    // horizontal line, in pixel clocks, counted from the leading edge of sync
    localparam logic [10:0] H_ACTIVE = 11'h320;
    localparam logic [10:0] H_SYNC_BP = 11'h058;
    localparam logic [10:0] H_ACT_END = H_SYNC_BP + H_ACTIVE;
    localparam logic [10:0] H_LAST_BASE = H_ACT_END - 11'h001;
    localparam logic [10:0] LINE_MIN = 11'h38C;
    localparam logic [10:0] LINE_MAX = 11'h440;
    localparam logic [7:0] HSW_MIN = 8'h01;
    localparam logic [7:0] HSW_MAX = 8'h57;
    localparam logic [7:0] HFP_MIN = 8'h14;
    localparam logic [7:0] HFP_MAX = 8'hC8;
    // vertical frame, in lines, counted from the leading edge of sync
    localparam logic [9:0] V_ACTIVE = 10'h1E0;
    localparam logic [9:0] V_SYNC_BP = 10'h020;
    localparam logic [9:0] V_ACT_END = V_SYNC_BP + V_ACTIVE;
    localparam logic [9:0] V_LAST_BASE = V_ACT_END - 10'h001;
    localparam logic [7:0] VSW_MIN = 8'h01;
    localparam logic [7:0] VSW_MAX = 8'h03;
    localparam logic [7:0] VFP_MIN = 8'h05;
    localparam logic [7:0] VFP_MAX_DUAL = 8'hC8;
    localparam logic [7:0] VFP_MAX_CASC = 8'h65;
    localparam logic [9:0] FRAME_MIN = 10'h205;
    localparam logic [9:0] FRAME_MAX_DUAL = 10'h2C8;
    localparam logic [9:0] FRAME_MAX_CASC = 10'h265;
    // pixel clock is core clock divided by twice this
    localparam logic [3:0] PCLK_HALF_DEF = 4'h4;
    localparam logic [1:0] RES_800X480 = 2'h0;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HTIM = 8'h04;
    localparam logic [7:0] REG_VTIM = 8'h08;
    localparam logic [7:0] REG_FILL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_UNDER = 8'h14;
    localparam int CTRL_EN = 0;
    localparam int CTRL_SMODE = 1;
    localparam int CTRL_DUAL = 2;
    localparam int CTRL_SHIFT = 3;
    localparam int TIM_WIDTH_LSB = 0;
    localparam int TIM_PORCH_LSB = 16;
    localparam int STAT_VPOS_LSB = 16;
    localparam int STAT_RUN_BIT = 31;
    localparam logic [31:0] CTRL_RST = 32'h0000_000E;
    localparam logic [31:0] HTIM_RST = 32'h0028_0030;
    localparam logic [31:0] VTIM_RST = 32'h000D_0001;
    localparam logic [31:0] FILL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_000F;
    localparam logic [31:0] TIM_MASK = 32'h00FF_00FF;
    localparam logic [31:0] FILL_MASK = 32'h00FF_FFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [ritm_axil_regs.sv]
`timescale 1ns/1ns
module ritm_axil_regs import ritm_pkg::*; (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] ctrl_word,
    output logic [31:0] htim_word,
    output logic [31:0] vtim_word,
    output logic [31:0] fill_word,
    input wire logic [15:0] stat_frames,
    input wire logic [9:0] stat_vpos,
    input wire logic stat_run,
    input wire logic [15:0] stat_under
);
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [31:0] htim;
        logic [31:0] vtim;
        logic [31:0] fill;
    } ritm_axil_t;

    ritm_axil_t s_reg;
    ritm_axil_t s_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // address and data are held until both are in, so they may come in either order
    assign s_axi_awready = !s_reg.aw_full && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_full && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign ctrl_word = s_reg.ctrl;
    assign htim_word = s_reg.htim;
    assign vtim_word = s_reg.vtim;
    assign fill_word = s_reg.fill;

    always_comb begin
        s_next = s_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_full = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_full = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
            s_next.aw_full = 1'b0;
            s_next.w_full = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            case (s_reg.aw_addr)
                REG_CTRL: s_next.ctrl = merge(s_reg.ctrl, s_reg.w_data, s_reg.w_strb) & CTRL_MASK;
                REG_HTIM: s_next.htim = merge(s_reg.htim, s_reg.w_data, s_reg.w_strb) & TIM_MASK;
                REG_VTIM: s_next.vtim = merge(s_reg.vtim, s_reg.w_data, s_reg.w_strb) & TIM_MASK;
                REG_FILL: s_next.fill = merge(s_reg.fill, s_reg.w_data, s_reg.w_strb) & FILL_MASK;
                REG_STATUS, REG_UNDER: s_next.bresp = RESP_OKAY;
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL: s_next.rdata = s_reg.ctrl;
                REG_HTIM: s_next.rdata = s_reg.htim;
                REG_VTIM: s_next.rdata = s_reg.vtim;
                REG_FILL: s_next.rdata = s_reg.fill;
                REG_STATUS: begin
                    s_next.rdata = '0;
                    s_next.rdata[15:0] = stat_frames;
                    s_next.rdata[STAT_VPOS_LSB +: 10] = stat_vpos;
                    s_next.rdata[STAT_RUN_BIT] = stat_run;
                end
                REG_UNDER: s_next.rdata = {16'h0000, stat_under};
                default: begin
                    s_next.rdata = '0;
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.ctrl <= CTRL_RST;
            s_reg.htim <= HTIM_RST;
            s_reg.vtim <= VTIM_RST;
            s_reg.fill <= FILL_RST;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // ritm_axil_regs

// [ritm_host.sv]
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module ritm_host import ritm_pkg::*; #(
    parameter logic [3:0] PCLK_HALF = PCLK_HALF_DEF
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [7:0] pix_red,
    input wire logic [7:0] pix_green,
    input wire logic [7:0] pix_blue,
    output logic pixel_clock,
    output logic horizontal_sync_in_n,
    output logic vertical_sync_in_n,
    output logic data_enable_in,
    output logic [7:0] red_in,
    output logic [7:0] green_in,
    output logic [7:0] blue_in,
    output logic sync_mode,
    output logic dual_gate_select,
    output logic shift_direction_select,
    output logic [1:0] resolution_select
);
    typedef struct packed {
        logic [3:0] div;
        logic pclk;
        logic run;
        logic [10:0] hcnt;
        logic [9:0] vcnt;
        logic [7:0] hsw;
        logic [7:0] hfp;
        logic [7:0] vsw;
        logic [7:0] vfp;
        logic dual;
        logic shift;
        logic smode;
        logic hs_n;
        logic vs_n;
        logic de;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic [15:0] frames;
        logic [15:0] under;
    } ritm_tg_t;

    ritm_tg_t s_reg;
    ritm_tg_t s_next;
    logic [31:0] ctrl_word;
    logic [31:0] htim_word;
    logic [31:0] vtim_word;
    logic [31:0] fill_word;
    logic [7:0] cfg_hsw;
    logic [7:0] cfg_hfp;
    logic [7:0] cfg_vsw;
    logic [7:0] cfg_vfp;
    logic [7:0] vfp_max;
    logic tick;
    logic [10:0] h_last;
    logic [9:0] v_last;
    logic active;

    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    ritm_axil_regs u_regs (
        .core_clk(core_clk),
        .reset(reset),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .ctrl_word(ctrl_word),
        .htim_word(htim_word),
        .vtim_word(vtim_word),
        .fill_word(fill_word),
        .stat_frames(s_reg.frames),
        .stat_vpos(s_reg.vcnt),
        .stat_run(s_reg.run),
        .stat_under(s_reg.under)
    );

    // software values are forced into the legal window, so no setting can break the panel
    assign cfg_hsw = clamp8(htim_word[TIM_WIDTH_LSB +: 8], HSW_MIN, HSW_MAX);
    assign cfg_hfp = clamp8(htim_word[TIM_PORCH_LSB +: 8], HFP_MIN, HFP_MAX);
    assign cfg_vsw = clamp8(vtim_word[TIM_WIDTH_LSB +: 8], VSW_MIN, VSW_MAX);
    assign vfp_max = ctrl_word[CTRL_DUAL] ? VFP_MAX_DUAL : VFP_MAX_CASC;
    assign cfg_vfp = clamp8(vtim_word[TIM_PORCH_LSB +: 8], VFP_MIN, vfp_max);

    assign pixel_clock = s_reg.pclk;
    assign horizontal_sync_in_n = s_reg.hs_n;
    assign vertical_sync_in_n = s_reg.vs_n;
    assign data_enable_in = s_reg.de;
    assign red_in = s_reg.red;
    assign green_in = s_reg.green;
    assign blue_in = s_reg.blue;
    assign sync_mode = s_reg.smode;
    assign dual_gate_select = s_reg.dual;
    assign shift_direction_select = s_reg.shift;
    // only the 800x480 timing is generated, so the panel format is pinned to it
    assign resolution_select = RES_800X480;

    always_comb begin
        s_next = s_reg;
        tick = 1'b0;
        active = 1'b0;
        pix_ready = 1'b0;
        // back porch is what is left of the fixed 88 after the sync pulse
        h_last = H_LAST_BASE + {3'h0, s_reg.hfp};
        v_last = V_LAST_BASE + {2'h0, s_reg.vfp};
        // new values launch on the falling pixel clock edge: a half period of setup and hold
        if (s_reg.div == PCLK_HALF - 4'h1) begin
            s_next.div = 4'h0;
            s_next.pclk = ~s_reg.pclk;
            tick = s_reg.pclk;
        end else begin
            s_next.div = s_reg.div + 4'h1;
        end
        if (tick) begin
            if (!s_reg.run) begin
                if (ctrl_word[CTRL_EN]) begin
                    s_next.run = 1'b1;
                    s_next.hcnt = 11'h000;
                    s_next.vcnt = 10'h000;
                end
            end else if (s_reg.hcnt == h_last) begin
                s_next.hcnt = 11'h000;
                if (s_reg.vcnt == v_last) begin
                    s_next.vcnt = 10'h000;
                    s_next.frames = s_reg.frames + 16'h0001;
                    // a disable takes effect only at a frame boundary
                    s_next.run = ctrl_word[CTRL_EN];
                end else begin
                    s_next.vcnt = s_reg.vcnt + 10'h001;
                end
            end else begin
                s_next.hcnt = s_reg.hcnt + 11'h001;
            end
            // settings are taken at frame start so one frame never mixes two timings
            if (s_next.hcnt == 11'h000 && s_next.vcnt == 10'h000) begin
                s_next.hsw = cfg_hsw;
                s_next.hfp = cfg_hfp;
                s_next.vsw = cfg_vsw;
                s_next.vfp = cfg_vfp;
                s_next.dual = ctrl_word[CTRL_DUAL];
                s_next.shift = ctrl_word[CTRL_SHIFT];
                s_next.smode = ctrl_word[CTRL_SMODE];
            end
            if (s_next.run) begin
                s_next.hs_n = !(s_next.hcnt < {3'h0, s_next.hsw});
                s_next.vs_n = !(s_next.vcnt < {2'h0, s_next.vsw});
                active = s_next.hcnt >= H_SYNC_BP && s_next.hcnt < H_ACT_END
                    && s_next.vcnt >= V_SYNC_BP && s_next.vcnt < V_ACT_END;
            end else begin
                s_next.hs_n = 1'b1;
                s_next.vs_n = 1'b1;
            end
            s_next.de = active;
            if (active) begin
                pix_ready = 1'b1;
                if (pix_valid) begin
                    s_next.red = pix_red;
                    s_next.green = pix_green;
                    s_next.blue = pix_blue;
                end else begin
                    // the line cannot stall, so a missing pixel is filled and counted
                    s_next.red = fill_word[23:16];
                    s_next.green = fill_word[15:8];
                    s_next.blue = fill_word[7:0];
                    s_next.under = s_reg.under + 16'h0001;
                end
            end else begin
                s_next.red = 8'h00;
                s_next.green = 8'h00;
                s_next.blue = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.hs_n <= 1'b1;
            s_reg.vs_n <= 1'b1;
            s_reg.smode <= CTRL_RST[CTRL_SMODE];
            s_reg.dual <= CTRL_RST[CTRL_DUAL];
            s_reg.shift <= CTRL_RST[CTRL_SHIFT];
        end else begin
            s_reg <= s_next;
        end
    end

    // helper counters seen only by the checks below
    logic [10:0] chk_pix;
    logic [8:0] chk_lines;
    logic chk_de_q;
    logic chk_vs_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            chk_pix <= 11'h000;
            chk_lines <= 9'h000;
            chk_de_q <= 1'b0;
            chk_vs_q <= 1'b1;
        end else begin
            chk_de_q <= s_reg.de;
            chk_vs_q <= s_reg.vs_n;
            if (tick) begin
                chk_pix <= s_reg.de ? chk_pix + 11'h001 : 11'h000;
            end
            if (chk_vs_q && !s_reg.vs_n) begin
                chk_lines <= 9'h000;
            end else if (s_reg.de && !chk_de_q) begin
                chk_lines <= chk_lines + 9'h001;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    pix_count_a: assert property (
        $fell(s_reg.de) |-> chk_pix == H_ACTIVE)
        else $error("active line not 800 pixels");
    hsync_width_a: assert property (
        $rose(s_reg.hs_n) |-> s_reg.hcnt >= {3'h0, HSW_MIN} && s_reg.hcnt <= {3'h0, HSW_MAX})
        else $error("horizontal sync width out of range");
    hsync_bp_a: assert property (
        $rose(s_reg.de) |-> s_reg.hcnt == H_SYNC_BP && s_reg.hs_n)
        else $error("active data not 88 clocks after sync");
    hfp_range_a: assert property (
        tick && s_reg.run && s_reg.hcnt == h_last
        |-> !s_reg.de && s_reg.hfp >= HFP_MIN && s_reg.hfp <= HFP_MAX)
        else $error("horizontal front porch out of range");
    line_len_a: assert property (
        tick && s_reg.run && s_reg.hcnt == h_last
        |-> s_reg.hcnt >= LINE_MIN - 11'h001 && s_reg.hcnt <= LINE_MAX - 11'h001)
        else $error("line period out of range");
    line_total_a: assert property (
        $fell(s_reg.vs_n) && s_reg.frames != 16'h0000 |-> chk_lines == 9'(V_ACTIVE))
        else $error("frame not 480 active lines");
    vsync_width_a: assert property (
        !s_reg.vs_n |-> s_reg.vcnt < 10'(s_reg.vsw) && s_reg.vcnt < {2'h0, VSW_MAX})
        else $error("vertical sync width out of range");
    vsync_bp_a: assert property (
        $rose(s_reg.de) |-> s_reg.vcnt >= V_SYNC_BP && s_reg.vcnt < V_ACT_END && s_reg.vs_n)
        else $error("active line outside 32 line offset");
    frame_len_a: assert property (
        tick && s_reg.run && s_reg.hcnt == h_last && s_reg.vcnt == v_last
        |-> s_reg.vcnt >= FRAME_MIN - 10'h001
            && s_reg.vcnt <= (s_reg.dual ? FRAME_MAX_DUAL : FRAME_MAX_CASC) - 10'h001)
        else $error("frame period out of range");
endmodule // ritm_host

// [ritm_dev_model.sv]
`timescale 1ns/1ns
module ritm_dev_model (
    input wire logic pixel_clock,
    input wire logic hsync_n,
    input wire logic vsync_n,
    input wire logic de,
    input wire logic [7:0] red_in,
    input wire logic [7:0] green_in,
    input wire logic [7:0] blue_in,
    input wire logic shift_direction_select,
    input wire logic dual_gate_select,
    output int hsw_seen,
    output int line_seen,
    output int vsw_seen,
    output int lines,
    output int de_early_cnt,
    output int pix_seen,
    output int tap_first,
    output logic [7:0] source_output_first,
    output logic [7:0] source_output_last
);
    int hcnt = 0;
    int pcnt = 0;
    logic h_q = 1'b1;
    logic v_q = 1'b1;
    logic de_q = 1'b0;
    logic gate_row = 1'b0;
    logic [7:0] head = 8'h00;
    logic [7:0] sub [3];

    // only the anchor codes are modelled; codes between them return 0
    function automatic int gamma_tap(input logic [5:0] code, input logic neg);
        case (code)
            6'h00: return neg ? 32'hE : 32'h1;
            6'h10: return neg ? 32'hC : 32'h3;
            6'h20: return neg ? 32'hB : 32'h4;
            6'h30: return neg ? 32'hA : 32'h5;
            6'h3F: return neg ? 32'h8 : 32'h7;
            default: return 32'h0;
        endcase
    endfunction

    // framed by the syncs only; enable is watched, not trusted
    always @(posedge pixel_clock) begin
        hcnt++;
        if (!hsync_n && h_q) begin
            line_seen = hcnt;
            hcnt = 0; // count from the leading edge
            lines++;
        end
        if (hsync_n && !h_q) hsw_seen = hcnt;
        if (!vsync_n && v_q) lines = 0;
        if (vsync_n && !v_q) vsw_seen = lines;
        if (de && lines < 32) de_early_cnt++;
        if (de) begin
            // a line fills two gate rows of 1200 subpixels each in dual gate mode
            gate_row = pcnt >= 400;
            if (!dual_gate_select) sub = '{red_in, green_in, blue_in};
            else if (!gate_row) sub = '{red_in, blue_in, green_in};
            else sub = '{green_in, red_in, blue_in};
            if (pcnt == 0) head = sub[0];
            pcnt++;
            if (shift_direction_select) begin
                source_output_first = head;
                source_output_last = sub[2];
            end else begin
                source_output_first = sub[2];
                source_output_last = head;
            end
            tap_first = gamma_tap(source_output_first[7:2], 1'b0);
        end else if (de_q) begin
            pix_seen = pcnt;
            pcnt = 0;
        end
        h_q = hsync_n;
        v_q = vsync_n;
        de_q = de;
    end
endmodule // ritm_dev_model

// [ritm_host_bench.sv]
`timescale 1ns/1ns
module ritm_host_bench;
    import ritm_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic wr;
        logic [31:0] wdata;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ritm_row_t;
    logic core_clk = 1'b0, reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pix_valid = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pix_ready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resolution_select, rs;
    logic [7:0] pix_red = 8'h11, pix_green = 8'h22, pix_blue = 8'hFC, red_in, green_in, blue_in;
    logic [7:0] so_first, so_last;
    logic pixel_clock, horizontal_sync_in_n, vertical_sync_in_n, data_enable_in;
    logic sync_mode, dual_gate_select, shift_direction_select;
    int fails = 0, checks = 0, hsw_seen, line_seen, vsw_seen, lines, de_early_cnt;
    int pix_seen, tap_first, taken = 0;
    ritm_row_t rows [11];

    always #2 core_clk = ~core_clk;

    // fastest pixel clock, so the first active line arrives within the run
    ritm_host #(.PCLK_HALF(4'h1)) dut_u (.*);
    ritm_dev_model dev_u (
        .pixel_clock(pixel_clock),
        .hsync_n(horizontal_sync_in_n),
        .vsync_n(vertical_sync_in_n),
        .de(data_enable_in),
        .red_in(red_in),
        .green_in(green_in),
        .blue_in(blue_in),
        .shift_direction_select(shift_direction_select),
        .dual_gate_select(dual_gate_select),
        .hsw_seen(hsw_seen),
        .line_seen(line_seen),
        .vsw_seen(vsw_seen),
        .lines(lines),
        .de_early_cnt(de_early_cnt),
        .pix_seen(pix_seen),
        .tap_first(tap_first),
        .source_output_first(so_first),
        .source_output_last(so_last)
    );

    // pixels handed over; read before the edge updates the ready pulse
    always @(posedge core_clk) begin
        if (pix_ready && pix_valid) taken++;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // sampled mid-cycle, so the handshake edge is the next rising one
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // the first active line ends near 60k cycles; this leaves margin
    initial begin
        #400000;
        fails++;
        stop_test();
    end

    initial begin
        rows = '{
            '{REG_CTRL, 1'b0, 32'h0, RESP_OKAY, CTRL_RST, RESP_OKAY},
            '{REG_HTIM, 1'b0, 32'h0, RESP_OKAY, HTIM_RST, RESP_OKAY},
            '{REG_VTIM, 1'b0, 32'h0, RESP_OKAY, VTIM_RST, RESP_OKAY},
            '{REG_FILL, 1'b0, 32'h0, RESP_OKAY, FILL_RST, RESP_OKAY},
            '{REG_UNDER, 1'b0, 32'h0, RESP_OKAY, 32'h0, RESP_OKAY},
            '{8'h18, 1'b0, 32'h0, RESP_OKAY, 32'h0, RESP_SLVERR},
            '{8'h18, 1'b1, 32'hFFFF_FFFF, RESP_SLVERR, 32'h0, RESP_SLVERR},
            '{REG_STATUS, 1'b1, 32'hFFFF_FFFF, RESP_OKAY, 32'h0, RESP_OKAY},
            '{REG_HTIM, 1'b1, 32'hFF05_FF60, RESP_OKAY, 32'h0005_0060, RESP_OKAY},
            '{REG_VTIM, 1'b1, 32'h0005_0005, RESP_OKAY, 32'h0005_0005, RESP_OKAY},
            '{REG_FILL, 1'b1, 32'hFFA5_5A3C, RESP_OKAY, 32'h00A5_5A3C, RESP_OKAY}
        };
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        chk("idle pins", 32'({7'h37, RES_800X480}), 32'({pixel_clock, horizontal_sync_in_n,
            vertical_sync_in_n, data_enable_in, sync_mode, dual_gate_select,
            shift_direction_select, resolution_select}));
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_wr(rows[i].addr, rows[i].wdata, rs);
                chk("bresp", 32'(rows[i].bresp), 32'(rs));
            end
            axi_rd(rows[i].addr, rd, rs);
            chk("rdata", rows[i].rdata, rd);
            chk("rresp", 32'(rows[i].rresp), 32'(rs));
        end
        // out-of-range widths and porch must come out clamped on the pins
        axi_wr(REG_CTRL, 32'h0000_0001, rs);
        for (int n = 0; n < 70000 && pix_seen == 0; n++)
            @(posedge core_clk);
        @(negedge core_clk);
        chk("hsync width", 32'(HSW_MAX), 32'(hsw_seen));
        chk("line length", 32'(H_ACT_END) + 32'(HFP_MIN), 32'(line_seen));
        chk("vsync width", 32'(VSW_MAX), 32'(vsw_seen));
        chk("early data", 32'h0, 32'(de_early_cnt));
        chk("pixels", 32'(H_ACTIVE), 32'(pix_seen));
        chk("pixels taken", 32'(H_ACTIVE), 32'(taken));
        chk("first output", 32'(pix_blue), 32'(so_first));
        chk("last output", 32'(pix_red), 32'(so_last));
        chk("gamma tap", 32'h7, 32'(tap_first));
        chk("straps", 32'h0, 32'({sync_mode, dual_gate_select, shift_direction_select}));
        axi_rd(REG_STATUS, rd, rs);
        chk("running", 32'h1, 32'(rd[STAT_RUN_BIT]));
        reset <= 1'b1;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        chk("reset pins", 32'h1B, 32'({horizontal_sync_in_n, vertical_sync_in_n,
            data_enable_in, sync_mode, dual_gate_select}));
        @(posedge core_clk);
        reset <= 1'b0;
        axi_rd(REG_CTRL, rd, rs);
        chk("ctrl after reset", CTRL_RST, rd);
        stop_test();
    end
endmodule // ritm_host_bench
